// File: src/dci_cfg.svh
// Constants of the debug command interpreter
`ifndef DCI_CFG_SVH
`define DCI_CFG_SVH
`define DCI_CMD_REV      8'h00
`define DCI_CMD_STAT     8'h02
`define DCI_CMD_RUNCNT   8'h03
`define DCI_CMD_CTL_WR   8'h04
`define DCI_CMD_CTL_RD   8'h05
`define DCI_CMD_PC_WR    8'h06
`define DCI_CNT_ZERO     16'h0000
`define DCI_CNT_MAX      16'hFFFF
`define DCI_CNT_ONE      16'h0001
`define DCI_CTL_RESET    8'h00
`define DCI_PC_RESET     16'h0000
`define DCI_BYTE_ZERO    8'h00
`define DCI_SHIFT_RESET  16'h0000
`define DCI_HALT_BIT     7
`endif

// File: src/dci_pkg.sv
// Types of the debug command interpreter
package dci_pkg;
  typedef enum logic [2:0] {
    DCI_IDLE  = 3'h0,
    DCI_SEND  = 3'h1,
    DCI_CTL   = 3'h2,
    DCI_PC_HI = 3'h3,
    DCI_PC_LO = 3'h4
  } dci_state_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dci_byte_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } dci_pc_type;
endpackage

// File: src/dci_interp.sv
// Command interpreter of the on-chip debugger
`timescale 1ns/1ps
`include "dci_cfg.svh"
module dci_interp
  import dci_pkg::*;
#(
  parameter logic [15:0] REVISION = 16'h0100  // Arbitrary revision value
)(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire dci_byte_type rx_byte,
  input  wire logic         tx_ready,
  input  wire logic [7:0]   status_in,
  input  wire logic         count_run,
  input  wire logic         count_overwrite,
  input  wire logic         read_protect,
  output dci_byte_type      tx_byte,
  output logic [7:0]        debugger_control_reg,
  output dci_pc_type        pc_load
);
  // Elaboration check: an all-zero revision is refused
  if (REVISION == `DCI_CNT_ZERO) begin : g_bad_revision
    $error("revision must be nonzero");
  end

  dci_state_type state_r, state_nxt;
  logic [15:0]   cnt_r, cnt_nxt;
  logic [7:0]    ctl_r, ctl_nxt;
  logic [7:0]    pc_hi_r, pc_hi_nxt;
  logic [15:0]   shift_r, shift_nxt;
  logic          two_r, two_nxt;
  dci_byte_type  tx_r, tx_nxt;
  dci_pc_type    pc_r, pc_nxt;

  // Applies a control write, keeping the halt bit set under protection
  function automatic logic [7:0] ctl_write(input logic [7:0] cur, input logic [7:0] wr,
                                           input logic prot);
    logic [7:0] v;
    v = wr;
    if (prot && cur[`DCI_HALT_BIT]) v[`DCI_HALT_BIT] = 1'b1;
    return v;
  endfunction

  // Command decoding, response sequencing and counter update
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ctl_nxt   = ctl_r;
    pc_hi_nxt = pc_hi_r;
    shift_nxt = shift_r;
    two_nxt   = two_r;
    tx_nxt    = tx_r;
    pc_nxt    = '0;
    if (count_overwrite) cnt_nxt = `DCI_CNT_ZERO;
    else if (count_run && cnt_r != `DCI_CNT_MAX) cnt_nxt = cnt_r + `DCI_CNT_ONE;
    if (tx_r.valid && tx_ready) tx_nxt.valid = 1'b0;
    unique case (state_r)
      DCI_IDLE: begin
        if (rx_byte.valid) begin
          unique case (rx_byte.data)
            `DCI_CMD_REV: begin
              shift_nxt = REVISION;
              two_nxt   = 1'b1;
              state_nxt = DCI_SEND;
            end
            `DCI_CMD_STAT: begin
              shift_nxt = {status_in, `DCI_BYTE_ZERO};
              two_nxt   = 1'b0;
              state_nxt = DCI_SEND;
            end
            `DCI_CMD_RUNCNT: begin
              shift_nxt = cnt_r;
              two_nxt   = 1'b1;
              state_nxt = DCI_SEND;
            end
            `DCI_CMD_CTL_RD: begin
              shift_nxt = {ctl_r, `DCI_BYTE_ZERO};
              two_nxt   = 1'b0;
              state_nxt = DCI_SEND;
            end
            `DCI_CMD_CTL_WR: state_nxt = DCI_CTL;
            `DCI_CMD_PC_WR:  state_nxt = DCI_PC_HI;
            default:         state_nxt = DCI_IDLE;
          endcase
        end
      end
      DCI_SEND: begin
        if (!tx_r.valid || tx_ready) begin
          tx_nxt.valid = 1'b1;
          tx_nxt.data  = shift_r[15:8];  // High byte first
          shift_nxt    = {shift_r[7:0], `DCI_BYTE_ZERO};
          two_nxt      = 1'b0;
          if (!two_r) state_nxt = DCI_IDLE;
        end
      end
      DCI_CTL: begin
        if (rx_byte.valid) begin
          ctl_nxt   = ctl_write(ctl_r, rx_byte.data, read_protect);
          state_nxt = DCI_IDLE;
        end
      end
      DCI_PC_HI: begin
        if (rx_byte.valid) begin
          pc_hi_nxt = rx_byte.data;
          state_nxt = DCI_PC_LO;
        end
      end
      DCI_PC_LO: begin
        if (rx_byte.valid) begin
          pc_nxt.value = {pc_hi_r, rx_byte.data};
          pc_nxt.valid = ctl_r[`DCI_HALT_BIT] && !read_protect;
          state_nxt    = DCI_IDLE;
        end
      end
      default: state_nxt = DCI_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= DCI_IDLE;
      cnt_r   <= `DCI_CNT_ZERO;
      ctl_r   <= `DCI_CTL_RESET;
      pc_hi_r <= `DCI_BYTE_ZERO;
      shift_r <= `DCI_SHIFT_RESET;
      two_r   <= 1'b0;
      tx_r    <= '0;
      pc_r    <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ctl_r   <= ctl_nxt;
      pc_hi_r <= pc_hi_nxt;
      shift_r <= shift_nxt;
      two_r   <= two_nxt;
      tx_r    <= tx_nxt;
      pc_r    <= pc_nxt;
    end
  end

  assign tx_byte              = tx_r;
  assign debugger_control_reg = ctl_r;
  assign pc_load              = pc_r;

  // Counter holds at its maximum
  a_cnt_saturate: assert property (@(posedge core_clk) disable iff (rst)
    cnt_r == `DCI_CNT_MAX && !count_overwrite |=> cnt_r == `DCI_CNT_MAX)
    else $error("runtime counter left its maximum");
  // Counter overwrite clears it
  a_cnt_clear: assert property (@(posedge core_clk) disable iff (rst)
    count_overwrite |=> cnt_r == `DCI_CNT_ZERO)
    else $error("runtime counter not overwritten");
  // Halt bit sticks under protection
  a_halt_sticky: assert property (@(posedge core_clk) disable iff (rst)
    read_protect && ctl_r[`DCI_HALT_BIT] |=> ctl_r[`DCI_HALT_BIT])
    else $error("halt bit cleared under protection");
  // PC load only in debug mode without protection
  a_pc_gate: assert property (@(posedge core_clk) disable iff (rst)
    state_r == DCI_PC_LO && rx_byte.valid && (read_protect || !ctl_r[`DCI_HALT_BIT])
    |=> !pc_r.valid)
    else $error("program counter written while locked");
  // PC value is high byte then low byte
  a_pc_order: assert property (@(posedge core_clk) disable iff (rst)
    pc_r.valid |-> pc_r.value[15:8] == $past(pc_hi_r))
    else $error("program counter byte order wrong");
  // Control write takes the data byte
  a_ctl_load: assert property (@(posedge core_clk) disable iff (rst)
    state_r == DCI_CTL && rx_byte.valid && !read_protect |=> ctl_r == $past(rx_byte.data))
    else $error("control register not loaded");
  // Revision answer comes major first
  sequence s_rev_cmd;
    state_r == DCI_IDLE && rx_byte.valid && rx_byte.data == `DCI_CMD_REV;
  endsequence
  a_rev_major: assert property (@(posedge core_clk) disable iff (rst)
    s_rev_cmd ##1 !tx_r.valid |=> tx_r.valid && tx_r.data == REVISION[15:8])
    else $error("revision major byte missing");
  // No answer while a control write expects its data byte
  a_data_quiet: assert property (@(posedge core_clk) disable iff (rst)
    state_r == DCI_CTL && !tx_r.valid |=> !tx_r.valid)
    else $error("answer sent during data phase");
  // Status read returns the status byte
  a_stat_read: assert property (@(posedge core_clk) disable iff (rst)
    state_r == DCI_IDLE && rx_byte.valid && rx_byte.data == `DCI_CMD_STAT
    |=> shift_r[15:8] == $past(status_in))
    else $error("status byte not captured");
  // Control read returns the control byte
  a_ctl_read: assert property (@(posedge core_clk) disable iff (rst)
    state_r == DCI_IDLE && rx_byte.valid && rx_byte.data == `DCI_CMD_CTL_RD
    |=> shift_r[15:8] == $past(ctl_r))
    else $error("control byte not captured");
  // An answer byte stands until the host takes it
  a_tx_hold: assert property (@(posedge core_clk) disable iff (rst)
    tx_r.valid && !tx_ready |=> tx_r.valid && tx_r.data == $past(tx_r.data))
    else $error("answer byte dropped before it was taken");
  // A program counter load lasts one cycle
  a_pc_pulse: assert property (@(posedge core_clk) disable iff (rst)
    pc_r.valid |=> !pc_r.valid)
    else $error("program counter load held too long");
  // Counter steps by one while running below its maximum
  a_cnt_step: assert property (@(posedge core_clk) disable iff (rst)
    count_run && !count_overwrite && cnt_r != `DCI_CNT_MAX
    |=> cnt_r == $past(cnt_r) + `DCI_CNT_ONE)
    else $error("runtime counter did not step");
  // Both program counter bytes land, high byte first, when unlocked
  sequence s_pc_bytes;
    state_r == DCI_PC_HI && rx_byte.valid ##1 state_r == DCI_PC_LO && rx_byte.valid;
  endsequence
  a_pc_load: assert property (@(posedge core_clk) disable iff (rst)
    s_pc_bytes ##0 (ctl_r[`DCI_HALT_BIT] && !read_protect)
    |=> pc_r.valid && pc_r.value == {$past(rx_byte.data, 2), $past(rx_byte.data)})
    else $error("program counter load missing");
endmodule

// File: dv/dci_host.sv
// Host debugger model that takes the answer bytes of the interpreter
`timescale 1ns/1ps
module dci_host
  import dci_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         slow,
  input  wire dci_byte_type tx_byte,
  output logic              tx_ready,
  output dci_byte_type      got
);
  logic ph_r = 1'b0;
  // Stalls every other cycle when slow, so answers must wait
  assign tx_ready = ~slow | ph_r;
  // Hands each taken byte to the bench, in arrival order
  always @(posedge core_clk) begin
    ph_r <= ~ph_r;
    got  <= '{tx_byte.valid & tx_ready, tx_byte.data};
  end
endmodule

// File: dv/dci_interp_tb.sv
// Self-checking bench of the debug command interpreter
`timescale 1ns/1ps
module dci_interp_tb;
  import dci_pkg::*;
  typedef struct {logic [7:0] cmd; int n; logic [15:0] exp;} dci_row_type;
  logic         core_clk = 1'b0, rst = 1'b1, slow = 1'b0, tx_ready;
  logic         count_run = 1'b0, count_overwrite = 1'b0, read_protect = 1'b0;
  logic [7:0]   status_in = 8'hA5, debugger_control_reg, d;
  logic [15:0]  v;
  logic [16:0]  pc_v = '0;
  dci_byte_type rx_byte = '0, tx_byte, got;
  dci_pc_type   pc_load;
  int           mismatches = 0, cmp_count = 0, pc_n = 0;
  localparam logic [15:0] REV = 16'h0203;  // Arbitrary revision value
  dci_row_type  rows [4] = '{'{8'h00, 2, REV}, '{8'h02, 1, 16'h00A5},
                             '{8'h05, 1, 16'h0000}, '{8'h03, 2, 16'h0000}};
  dci_interp #(.REVISION(REV)) dut (.core_clk(core_clk), .rst(rst), .rx_byte(rx_byte),
    .tx_ready(tx_ready),
    .status_in(status_in), .count_run(count_run), .count_overwrite(count_overwrite),
    .read_protect(read_protect), .tx_byte(tx_byte),
    .debugger_control_reg(debugger_control_reg), .pc_load(pc_load));
  dci_host host (.core_clk(core_clk), .slow(slow), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .got(got));
  // Clock and watchdog
  initial forever #50 core_clk = ~core_clk;
  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    results();
  end
  // Counts every program counter load
  always @(posedge core_clk) if (pc_load.valid === 1'b1) begin
    pc_n++;
    pc_v = pc_load;
  end
  task automatic chk(input string name, input logic [16:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One byte to the interpreter; valid stays up for a following byte
  task automatic send(input logic [7:0] b);
    rx_byte = '{1'b1, b};
    @(posedge core_clk);
    #1;
  endtask
  // Waits, bounded, for the next byte the host took
  task automatic get(output logic [7:0] b);
    int k = 0;
    do begin
      @(posedge core_clk);
      #1 k++;
    end while (got.valid !== 1'b1 && k < 20);
    chk("answer", 17'(got.valid), 17'h1);
    b = got.data;
  endtask
  task automatic ask(input logic [7:0] c, input int n, output logic [15:0] r);
    send(c);
    rx_byte = '0;
    r = '0;
    repeat (n) begin
      get(d);
      r = {r[7:0], d};
    end
  endtask
  task automatic ctlw(input logic [7:0] b);
    send(8'h04);
    send(b);
    rx_byte = '0;
  endtask
  task automatic pcw(input logic [7:0] h, l);
    send(8'h06);
    send(h);
    send(l);
    rx_byte = '0;
    tick(3);
  endtask
  task results;
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence: table rows, then the awkward cases
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    chk("ctl_rst", 17'(debugger_control_reg), 17'h0);
    chk("tx_rst", 17'(tx_byte), 17'h0);
    chk("pc_rst", 17'(pc_load), 17'h0);
    foreach (rows[i]) begin
      ask(rows[i].cmd, rows[i].n, v);
      chk("row", 17'(v), 17'(rows[i].exp));
    end
    count_run = 1'b1;
    tick(10);
    count_run = 1'b0;
    ask(8'h03, 2, v);
    chk("count", 17'(v), 17'h000A);
    slow = 1'b1;
    count_run = 1'b1;
    tick(65540);
    count_run = 1'b0;
    ask(8'h03, 2, v);
    chk("sat", 17'(v), 17'h0FFFF);
    count_overwrite = 1'b1;
    tick(1);
    count_overwrite = 1'b0;
    ask(8'h03, 2, v);
    chk("clr", 17'(v), 17'h0);
    ctlw(8'h05);
    tick(4);
    chk("ctl", 17'(debugger_control_reg), 17'h05);
    chk("quiet", 17'(tx_byte.valid), 17'h0);
    pcw(8'h12, 8'h34);
    chk("pc_off", pc_n[16:0], 17'h0);
    ctlw(8'h80);
    pcw(8'hAB, 8'hCD);
    chk("pc", pc_v, 17'h1ABCD);
    read_protect = 1'b1;
    pcw(8'h55, 8'h66);
    chk("pc_prot", pc_n[16:0], 17'h1);
    ctlw(8'h00);
    send(8'h01);
    rx_byte = '0;
    tick(2);
    chk("unknown", 17'(tx_byte.valid), 17'h0);
    ask(8'h05, 1, v);
    chk("ctl_prot", 17'(v), 17'h80);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    chk("ctl_rst2", 17'(debugger_control_reg), 17'h0);
    chk("tx_rst2", 17'(tx_byte), 17'h0);
    chk("pc_rst2", 17'(pc_load), 17'h0);
    results();
  end
endmodule
